//--- core/srd_pkg.sv
/*
 Constants, field layout and register map of the 16-bit serial register
 command decoder, shared by the device end and the host end.
 Assumes both ends are compiled after this package.
*/
// Overview of operation
// - address field bits 13..9 picks the register
// - read-back 00, bit8 one, returns register
// - read-back with bit7 set returns id and pins in reply bits 6..0 only
// - write 01 replies fixed then extended status
// - flag read 11, bit7 picks low/high flags for reply bits 6..0
// - on writes host sets bit8 only for enabled odd parity
// - bit8 one when other fifteen ones even
// - parity checked when misc bit6 set, else bit8 must be zero
// - address 0 analog select, 1..4 scratch bytes
// - addresses 5..8 init registers read back
// - special mode entered by inverted random code
// - addresses 10..12 timer registers read back
// - mode write; reads give mode, code, debug exit
// - addresses 15..18 control registers with flags
package srd_pkg;
   // ****************************************
   // frame layout
   // ****************************************
   localparam int FRAME_BITS = 16;
   localparam int POS_CMD_HI = 15;
   localparam int POS_CMD_LO = 14;
   localparam int POS_ADDR_HI = 13;
   localparam int POS_ADDR_LO = 9;
   localparam int POS_PN = 8;
   localparam int POS_SUB = 7;
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_RSVD = 2'h2;
   localparam logic [1:0] CMD_FLAG = 2'h3;
   // ****************************************
   // register map
   // ****************************************
   localparam int REG_COUNT = 19;
   localparam logic [4:0] ADDR_ANALOG_SELECT_CTRL = 5'h00;
   localparam logic [4:0] ADDR_SCRATCH_BYTE_A = 5'h01;
   localparam logic [4:0] ADDR_SCRATCH_BYTE_B = 5'h02;
   localparam logic [4:0] ADDR_SCRATCH_BYTE_C = 5'h03;
   localparam logic [4:0] ADDR_SCRATCH_BYTE_D = 5'h04;
   localparam logic [4:0] ADDR_REGULATOR_INIT = 5'h05;
   localparam logic [4:0] ADDR_WATCHDOG_INIT = 5'h06;
   localparam logic [4:0] ADDR_SERIAL_BUS_IO_INIT = 5'h07;
   localparam logic [4:0] ADDR_MISC_INIT = 5'h08;
   localparam logic [4:0] ADDR_SPECIAL_MODE_ENTRY = 5'h09;
   localparam logic [4:0] ADDR_TIMER_SET_A = 5'h0a;
   localparam logic [4:0] ADDR_TIMER_SET_B = 5'h0b;
   localparam logic [4:0] ADDR_TIMER_SET_C = 5'h0c;
   localparam logic [4:0] ADDR_WATCHDOG_REFRESH = 5'h0d;
   localparam logic [4:0] ADDR_OPERATING_MODE = 5'h0e;
   localparam logic [4:0] ADDR_REGULATOR_CTRL = 5'h0f;
   localparam logic [4:0] ADDR_BUS_TRANSCEIVER_CTRL = 5'h10;
   localparam logic [4:0] ADDR_PIN_IO_CTRL = 5'h11;
   localparam logic [4:0] ADDR_IRQ_CTRL = 5'h12;
   localparam int PAR_EN_BIT = 6;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_HALF_NS = 400;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef logic [4:0] srd_addr_t;
endpackage

//--- core/srd_spi_if.sv
/*
 Four-wire serial link between host and device ends.
 Assumes the bench instantiates it and connects both modports.
*/
`timescale 1ns/10ps
interface srd_spi_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport host (output sclk, output cs_n, output mosi, input miso);
   modport dev (input sclk, input cs_n, input mosi, output miso);
endinterface

//--- core/srd_dev.sv
/*
 Device end: decodes 16-bit frames into register writes, reads and
 flag reads, clocked by the link clock only.
 Assumes clock idles low, data taken on rising edge, reply changed on
 falling edge, and chip select set up before the first rising edge.
*/
`timescale 1ns/10ps
module srd_dev (
   // reset
   input wire logic RSTN_IN,
   // link
   srd_spi_if.dev SPI,
   // core status, asynchronous to the link
   input wire logic [7:0] FIXED_STATUS_IN,
   input wire logic [7:0] EXT_STATUS_IN,
   input wire logic [7:0] ID_IO_IN,
   input wire logic [7:0] RAND_CODE_IN,
   input wire logic [7:0] CUR_MODE_IN,
   input wire logic [63:0] FLAGS_IN,
   // events toward the core, toggles on the link clock
   output logic WR_TGL_OUT,
   output srd_pkg::srd_addr_t WR_ADDR_OUT,
   output logic [7:0] WR_DATA_OUT,
   output logic PAR_ERR_TGL_OUT,
   output logic WDOG_TGL_OUT,
   output logic SPECIAL_MODE_ENTRY_TGL_OUT,
   output logic DEBUG_EXIT_TGL_OUT,
   // configuration
   output logic PARITY_EN_OUT
);
   import srd_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic [4:0] cnt;
   logic [14:0] rx;
   logic [15:0] tx;
   logic [7:0] regs [0:REG_COUNT-1];
   logic [7:0] stat_m, stat_s, ext_m, ext_s, id_m, id_s;
   logic [7:0] rand_m, rand_s, mode_m, mode_s;
   logic [63:0] flag_m, flag_s;
   logic frame_rst_n;
   logic [15:0] word;
   logic frame_end;
   logic [1:0] w_cmd;
   srd_addr_t w_addr;
   logic [7:0] w_data;
   logic par_calc, par_ok, wr_ok;
   logic [1:0] r_cmd;
   srd_addr_t r_addr;
   srd_addr_t flag_off;
   logic r_sub;
   logic [7:0] reply;
   logic [5:0] flag_sel;

   // ****************************************
   // core status synchronisers
   // ****************************************
   // two stages on the link clock; it only runs in frames,
   // so status is at least two edges old when sent
   always_ff @(posedge SPI.sclk or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         stat_m <= 8'h00;
         stat_s <= 8'h00;
         ext_m <= 8'h00;
         ext_s <= 8'h00;
         id_m <= 8'h00;
         id_s <= 8'h00;
         rand_m <= 8'h00;
         rand_s <= 8'h00;
         mode_m <= 8'h00;
         mode_s <= 8'h00;
         flag_m <= 64'h0;
         flag_s <= 64'h0;
      end else begin
         stat_m <= FIXED_STATUS_IN;
         stat_s <= stat_m;
         ext_m <= EXT_STATUS_IN;
         ext_s <= ext_m;
         id_m <= ID_IO_IN;
         id_s <= id_m;
         rand_m <= RAND_CODE_IN;
         rand_s <= rand_m;
         mode_m <= CUR_MODE_IN;
         mode_s <= mode_m;
         flag_m <= FLAGS_IN;
         flag_s <= flag_m;
      end
   end

   // ****************************************
   // frame receive
   // ****************************************
   // chip select high clears the count, no edge after frame needed
   assign frame_rst_n = RSTN_IN & ~SPI.cs_n;

   // bit count saturates at a full frame
   always_ff @(posedge SPI.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt <= 5'h00;
      end else if (cnt != 5'(FRAME_BITS)) begin
         cnt <= cnt + 5'h01;
      end
   end

   // shift in, most significant bit first
   always_ff @(posedge SPI.sclk or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rx <= 15'h0000;
      end else begin
         rx <= {rx[13:0], SPI.mosi};
      end
   end

   // ****************************************
   // write decode
   // ****************************************
   // address field decode
   assign word = {rx, SPI.mosi};
   assign frame_end = (cnt == 5'(FRAME_BITS - 1));
   assign w_cmd = word[POS_CMD_HI:POS_CMD_LO];
   assign w_addr = word[POS_ADDR_HI:POS_ADDR_LO];
   assign w_data = word[7:0];
   assign par_calc = ~^{word[15:9], word[7:0]};
   assign par_ok = regs[ADDR_MISC_INIT][PAR_EN_BIT] ? (word[POS_PN] == par_calc) : ~word[POS_PN];
   assign wr_ok = frame_end && (w_cmd == CMD_WRITE) && par_ok && (w_addr <= ADDR_IRQ_CTRL);

   // per-register storage; refresh address is write-only
   generate
      for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
         always_ff @(posedge SPI.sclk or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               regs[i] <= REG_RESET;
            end else if (wr_ok && (w_addr == 5'(i)) && (5'(i) != ADDR_WATCHDOG_REFRESH)) begin
               regs[i] <= w_data;
            end
         end
      end
   endgenerate

   assign PARITY_EN_OUT = regs[ADDR_MISC_INIT][PAR_EN_BIT];

   // last accepted write, for the core
   always_ff @(posedge SPI.sclk or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         WR_TGL_OUT <= 1'b0;
         WR_ADDR_OUT <= 5'h00;
         WR_DATA_OUT <= 8'h00;
      end else if (wr_ok) begin
         WR_TGL_OUT <= ~WR_TGL_OUT;
         WR_ADDR_OUT <= w_addr;
         WR_DATA_OUT <= w_data;
      end
   end

   // side effects of writes and flag reads
   always_ff @(posedge SPI.sclk or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         PAR_ERR_TGL_OUT <= 1'b0;
         WDOG_TGL_OUT <= 1'b0;
         SPECIAL_MODE_ENTRY_TGL_OUT <= 1'b0;
         DEBUG_EXIT_TGL_OUT <= 1'b0;
      end else begin
         if (frame_end && (w_cmd == CMD_WRITE) && !par_ok) begin
            PAR_ERR_TGL_OUT <= ~PAR_ERR_TGL_OUT;
         end
         if (wr_ok && (w_addr == ADDR_WATCHDOG_REFRESH)) begin
            WDOG_TGL_OUT <= ~WDOG_TGL_OUT;
         end
         if (wr_ok && (w_addr == ADDR_SPECIAL_MODE_ENTRY) && (w_data == ~rand_s)) begin
            SPECIAL_MODE_ENTRY_TGL_OUT <= ~SPECIAL_MODE_ENTRY_TGL_OUT;
         end
         if (frame_end && (w_cmd == CMD_FLAG) && (w_addr == ADDR_OPERATING_MODE) && word[POS_SUB]) begin
            DEBUG_EXIT_TGL_OUT <= ~DEBUG_EXIT_TGL_OUT;
         end
      end
   end

   // ****************************************
   // reply select
   // ****************************************
   // evaluated after bit 8 (sub assumed low) and again after bit 7
   always_comb begin
      r_cmd = (cnt == 5'h08) ? rx[7:6] : rx[8:7];
      r_addr = (cnt == 5'h08) ? rx[5:1] : rx[6:2];
      r_sub = (cnt == 5'h08) ? 1'b0 : rx[0];
      flag_off = r_addr - ADDR_REGULATOR_CTRL;
      flag_sel = {flag_off[1:0], r_sub, 3'h0};
      reply = 8'h00;
      case (r_cmd)
         CMD_READ: begin
            if (r_sub) begin
               reply = id_s;
            end else if (r_addr == ADDR_SPECIAL_MODE_ENTRY) begin
               reply = rand_s;
            end else if (r_addr == ADDR_OPERATING_MODE) begin
               reply = mode_s;
            end else if ((r_addr <= ADDR_IRQ_CTRL) && (r_addr != ADDR_WATCHDOG_REFRESH)) begin
               reply = regs[r_addr];
            end
         end
         CMD_WRITE: reply = ext_s;
         CMD_FLAG: begin
            if ((r_addr >= ADDR_REGULATOR_CTRL) && (r_addr <= ADDR_IRQ_CTRL)) begin
               reply = flag_s[flag_sel +: 8];
            end else if (r_addr == ADDR_OPERATING_MODE) begin
               reply = r_sub ? mode_s : rand_s;
            end
         end
         default: reply = 8'h00;
      endcase
   end

   // ****************************************
   // reply shift out
   // ****************************************
   // falling edge; fixed status for the next frame is loaded
   // at the last falling edge so bit 15 stands before edge one
   always_ff @(negedge SPI.sclk or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         tx <= 16'h0000;
         SPI.miso <= 1'b0;
      end else if (cnt == 5'(FRAME_BITS)) begin
         tx <= {stat_s, 8'h00};
         SPI.miso <= stat_s[7];
      end else if (cnt == 5'h08) begin
         tx[7:0] <= reply;
         SPI.miso <= reply[7];
      end else if (cnt == 5'h09) begin
         // sub-address only known now, bit 7 already sent
         tx[6:0] <= reply[6:0];
         SPI.miso <= reply[6];
      end else if (cnt != 5'h00) begin
         SPI.miso <= tx[4'hf - cnt[3:0]];
      end
   end
endmodule // srd_dev

//--- core/srd_host.sv
/*
 Host end: builds 16-bit frames from user requests, derives the link
 clock from its own clock by a divider and returns the reply word.
 Assumes the device takes data on the rising link clock edge.
*/
`timescale 1ns/10ps
module srd_host #(
   parameter int SCLK_HALF = srd_pkg::SCLK_HALF_CYC
) (
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RSTN_IN,
   // link
   srd_spi_if.host SPI,
   // request
   input wire logic REQ_IN,
   input wire logic [15:0] REQ_WORD_IN,
   input wire logic PAR_EN_IN,
   // answer
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output logic [15:0] RESP_OUT
);
   import srd_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_LEAD = 6'b000010,
      ST_HIGH = 6'b000100,
      ST_LOW = 6'b001000,
      ST_TRAIL = 6'b010000,
      ST_GAP = 6'b100000
   } srd_state_t;
   srd_state_t state;
   logic [7:0] div;
   logic half_done;
   logic [3:0] bit_idx;
   logic [15:0] shreg, rx, frame;
   logic miso_m, miso_s;
   logic accept;

   // ****************************************
   // frame build
   // ****************************************
   always_comb begin
      frame = REQ_WORD_IN;
      case (REQ_WORD_IN[POS_CMD_HI:POS_CMD_LO])
         CMD_WRITE: frame[POS_PN] = PAR_EN_IN & ~^{REQ_WORD_IN[15:9], REQ_WORD_IN[7:0]};
         CMD_READ: frame = {REQ_WORD_IN[15:9], 1'b1, REQ_WORD_IN[POS_SUB], 7'h00};
         CMD_FLAG: frame[POS_PN] = 1'b1;
         default: frame = REQ_WORD_IN;
      endcase
   end
   assign accept = (state == ST_IDLE) && REQ_IN && (REQ_WORD_IN[POS_CMD_HI:POS_CMD_LO] != CMD_RSVD);

   // ****************************************
   // link clock divider and sequencing
   // ****************************************
   assign half_done = (div == 8'(SCLK_HALF - 1));

   // half-period counter
   always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         div <= 8'h00;
      end else if ((state == ST_IDLE) || half_done) begin
         div <= 8'h00;
      end else begin
         div <= div + 8'h01;
      end
   end

   // miso from the pin, two stages
   always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         miso_m <= 1'b0;
         miso_s <= 1'b0;
      end else begin
         miso_m <= SPI.miso;
         miso_s <= miso_m;
      end
   end

   // state, pins and shift registers
   always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state <= ST_IDLE;
         SPI.sclk <= 1'b0;
         SPI.cs_n <= 1'b1;
         SPI.mosi <= 1'b0;
         shreg <= 16'h0000;
         rx <= 16'h0000;
         bit_idx <= 4'h0;
         BUSY_OUT <= 1'b0;
         DONE_OUT <= 1'b0;
         RESP_OUT <= 16'h0000;
      end else begin
         DONE_OUT <= 1'b0;
         unique case (state)
            ST_IDLE: if (accept) begin
               state <= ST_LEAD;
               SPI.cs_n <= 1'b0;
               SPI.mosi <= frame[15];
               shreg <= frame;
               bit_idx <= 4'h0;
               BUSY_OUT <= 1'b1;
            end
            ST_LEAD: if (half_done) begin
               state <= ST_HIGH;
               SPI.sclk <= 1'b1;
            end
            ST_HIGH: if (half_done) begin
               // sample late in the high phase, reply changed two phases ago
               rx <= {rx[14:0], miso_s};
               SPI.sclk <= 1'b0;
               bit_idx <= bit_idx + 4'h1;
               if (bit_idx == 4'(FRAME_BITS - 1)) begin
                  state <= ST_TRAIL;
               end else begin
                  state <= ST_LOW;
                  SPI.mosi <= shreg[14];
                  shreg <= {shreg[14:0], 1'b0};
               end
            end
            ST_LOW: if (half_done) begin
               state <= ST_HIGH;
               SPI.sclk <= 1'b1;
            end
            ST_TRAIL: if (half_done) begin
               state <= ST_GAP;
               SPI.cs_n <= 1'b1;
               DONE_OUT <= 1'b1;
               RESP_OUT <= rx;
            end
            ST_GAP: if (half_done) begin
               state <= ST_IDLE;
               BUSY_OUT <= 1'b0;
            end
         endcase
      end
   end
endmodule // srd_host

//--- tb/srd_spi_sva.sv
/*
 Checker for the four-wire link between host and device ends.
 Assumes it is instantiated beside the interface, sampled on MCLK_IN.
*/
`timescale 1ns/10ps
module srd_spi_sva (
   // clock, reset, host parity setting
   input wire logic MCLK_IN,
   input wire logic RSTN_IN,
   input wire logic PAR_EN_IN,
   // link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   // ****************************************
   // frame capture
   // ****************************************
   logic sclk_q;
   logic [4:0] bit_cnt;
   logic [15:0] word;
   // previous link clock level, to spot rising edges
   always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) sclk_q <= 1'b0;
      else sclk_q <= sclk;
   end
   // shift mosi in on each rising link clock; count cleared between frames
   always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         bit_cnt <= 5'h00;
         word <= 16'h0000;
      end else if (cs_n) begin
         bit_cnt <= 5'h00;
      end else if (sclk && !sclk_q) begin
         bit_cnt <= bit_cnt + 5'h01;
         word <= {word[14:0], mosi};
      end
   end
   // ****************************************
   // link properties
   // ****************************************
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RSTN_IN);
   sequence s_frame_open;
      $fell(cs_n);
   endsequence
   sequence s_frame_done;
      $rose(cs_n);
   endsequence
   a_idle_clock_low: assert property (cs_n |-> !sclk)
      else $error("link clock high outside a frame");
   a_frame_sixteen: assert property (s_frame_done |-> bit_cnt == 5'h10)
      else $error("frame not sixteen bits");
   a_frame_span: assert property (s_frame_open |-> ##[128:136] $rose(cs_n))
      else $error("frame length wrong");
   a_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("mosi moved while clock high");
   a_miso_held_high: assert property (sclk && $past(sclk) |-> $stable(miso))
      else $error("miso moved while clock high");
   a_read_next_bit: assert property (s_frame_done ##0 word[15:14] == 2'h0 |-> word[8] && word[6:0] == 7'h00)
      else $error("read frame bit 8 or low bits wrong");
   a_flag_next_bit: assert property (s_frame_done ##0 word[15:14] == 2'h3 |-> word[8])
      else $error("flag read bit 8 low");
   a_write_parity: assert property (s_frame_done ##0 word[15:14] == 2'h1
      |-> word[8] == (PAR_EN_IN & ~^{word[15:9], word[7:0]}))
      else $error("write parity bit wrong");
   a_no_reserved: assert property (s_frame_done |-> word[15:14] != 2'h2)
      else $error("reserved command sent");
endmodule // srd_spi_sva

//--- tb/tb_spi_register_command_decoder.sv
/*
 Bench joining host and device ends; drives host requests, device status.
 Assumes package, interface and both ends are compiled first.
*/
`timescale 1ns/10ps
module tb_spi_register_command_decoder;
   import srd_pkg::*;
   // ****************************************
   // wiring
   // ****************************************
   logic mclk = 1'b0;
   // starts high so the first drop is a real falling edge for both ends
   logic rstn = 1'b1;
   logic req = 1'b0;
   logic [15:0] req_word = 16'h0000;
   logic par_en = 1'b0;
   logic busy, done, seen, sv;
   logic [15:0] resp;
   logic [7:0] fixed_st = 8'ha5;
   logic [7:0] ext_st = 8'h3c;
   logic [7:0] id_io = 8'h67;
   logic [7:0] rand_code = 8'h69;
   logic [7:0] cur_mode = 8'h07;
   logic [63:0] flags = 64'h1877665544332211;
   logic wr_tgl, perr_tgl, wdog_tgl, spe_tgl, dbg_tgl, par_on;
   srd_addr_t wr_addr;
   logic [7:0] wr_data;
   int mismatches = 0;
   int total_checks = 0;
   // frame word and reply expected; status byte is one frame old
   logic [31:0] rows [19] = '{32'h425a_003c, 32'h0300_a55a, 32'h58c3_a53c, 32'h1900_a5c3,
      32'h4a81_a53c, 32'h0b00_a581, 32'h0180_a567, 32'h1300_a569, 32'h1d00_a507,
      32'hdf00_a511, 32'he580_a518, 32'h5a00_a53c, 32'h1b00_a500, 32'hdd80_a507,
      32'h4068_a53c, 32'h0100_a568, 32'h605b_a53c, 32'h2100_a55b, 32'h2700_a500};
   srd_spi_if spi_if ();
   srd_host #(.SCLK_HALF(SCLK_HALF_CYC)) srd_host_i (.MCLK_IN(mclk), .RSTN_IN(rstn), .SPI(spi_if.host),
      .REQ_IN(req), .REQ_WORD_IN(req_word), .PAR_EN_IN(par_en), .BUSY_OUT(busy), .DONE_OUT(done),
      .RESP_OUT(resp));
   srd_dev srd_dev_i (.RSTN_IN(rstn), .SPI(spi_if.dev), .FIXED_STATUS_IN(fixed_st), .EXT_STATUS_IN(ext_st),
      .ID_IO_IN(id_io), .RAND_CODE_IN(rand_code), .CUR_MODE_IN(cur_mode), .FLAGS_IN(flags),
      .WR_TGL_OUT(wr_tgl), .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data), .PAR_ERR_TGL_OUT(perr_tgl),
      .WDOG_TGL_OUT(wdog_tgl), .SPECIAL_MODE_ENTRY_TGL_OUT(spe_tgl), .DEBUG_EXIT_TGL_OUT(dbg_tgl),
      .PARITY_EN_OUT(par_on));
   srd_spi_sva srd_spi_sva_i (.MCLK_IN(mclk), .RSTN_IN(rstn), .PAR_EN_IN(par_en), .sclk(spi_if.sclk),
      .cs_n(spi_if.cs_n), .mosi(spi_if.mosi), .miso(spi_if.miso));
   // 10 MHz system clock
   initial begin
      forever #50 mclk = ~mclk;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask
   // a hang is counted as a mismatch and ends the run
   task automatic bound(input int i, input int lim);
      if (i >= lim) begin
         mismatches++;
         $display("Error at %0t: handshake timed out", $time);
         wrap_up();
      end
   endtask
   task automatic do_reset();
      // a step off time zero, so the drop is seen by both ends
      #1;
      rstn = 1'b0;
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
   endtask
   // request held until the answer, then released; waits out the gap
   task automatic xfer(input logic [15:0] w, input logic [15:0] exp);
      int i;
      @(negedge mclk);
      req = 1'b1;
      req_word = w;
      for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge mclk);
      bound(i, 400);
      req = 1'b0;
      check(resp, exp);
      for (i = 0; i < 50 && busy !== 1'b0; i++) @(negedge mclk);
      bound(i, 50);
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      do_reset();
      // idle link: select high, clock low
      check({14'h0000, spi_if.cs_n, spi_if.sclk}, 16'h0002);
      foreach (rows[k]) xfer(rows[k][31:16], rows[k][15:0]);
      check({15'h0000, dbg_tgl}, 16'h0001);
      check({15'h0000, wdog_tgl}, 16'h0001);
      $display("table rows done");
      // reserved code never leaves the host and changes nothing
      @(negedge mclk);
      req = 1'b1;
      req_word = 16'h8200;
      @(negedge mclk);
      req = 1'b0;
      seen = 1'b0;
      repeat (150) begin
         @(negedge mclk);
         seen = seen | busy | done;
      end
      check({15'h0000, seen}, 16'h0000);
      xfer(16'h0300, 16'ha55a);
      $display("reserved test done");
      // parity enabled by misc bit 6, then good and bad write
      xfer(16'h5040, 16'ha53c);
      check({15'h0000, par_on}, 16'h0001);
      check({15'h0000, wr_tgl}, 16'h0001);
      par_en = 1'b1;
      xfer(16'h4469, 16'ha53c);
      check({3'h0, wr_addr, wr_data}, 16'h0269);
      par_en = 1'b0;
      sv = perr_tgl;
      xfer(16'h4640, 16'ha53c);
      check({15'h0000, perr_tgl}, {15'h0000, ~sv});
      xfer(16'h0700, 16'ha500);
      $display("parity test done");
      // inverted random code enters special mode
      par_en = 1'b1;
      sv = spe_tgl;
      xfer(16'h5296, 16'ha53c);
      check({15'h0000, spe_tgl}, {15'h0000, ~sv});
      check({15'h0000, wr_tgl}, 16'h0001);
      $display("special mode test done");
      // second reset clears registers and parity enable
      fixed_st = 8'h3b;
      do_reset();
      check({15'h0000, par_on}, 16'h0000);
      xfer(16'h0300, 16'h0000);
      xfer(16'h0300, 16'h3b00);
      $display("reset test done");
      wrap_up();
   end
endmodule // tb_spi_register_command_decoder
